// >>> dac_consts.vh
// register map, field positions, reset values and codes of the dual current dac
`ifndef DAC_CONSTS_VH
`define DAC_CONSTS_VH

// -----------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define IDX_DAC0_DATA_LOW 8'h96
`define IDX_DAC0_DATA_HIGH 8'h97
`define IDX_DAC1_CONTROL 8'hb5
`define IDX_DAC0_CONTROL 8'hb9
`define IDX_REFERENCE_CONTROL 8'hd1
`define IDX_DAC1_DATA_LOW 8'hf4
`define IDX_DAC1_DATA_HIGH 8'hf5

// -----------------------------------------------------------------
// control register fields
// -----------------------------------------------------------------
`define CTL_ENABLE_BIT 7
`define CTL_SOURCE_MSB 6
`define CTL_SOURCE_LSB 4
`define CTL_RESERVED_BIT 3
`define CTL_RJST_BIT 2
`define CTL_FS_MSB 1
`define CTL_FS_LSB 0
`define REF_MERGE_BIT 7

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define CTL_RESET 8'h73
`define DATA_RESET 8'h00
`define REF_RESET 8'h00

// -----------------------------------------------------------------
// update source codes
// -----------------------------------------------------------------
`define SRC_TIMER0 3'h0
`define SRC_TIMER1 3'h1
`define SRC_TIMER2 3'h2
`define SRC_TIMER3 3'h3
`define SRC_STROBE_RISE 3'h4
`define SRC_STROBE_FALL 3'h5
`define SRC_STROBE_ANY 3'h6
`define SRC_HIGH_WRITE 3'h7

// -----------------------------------------------------------------
// bus responses
// -----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> dac_channel.v
// one dac channel: control and data bytes, update selection, input latch
`timescale 1ns/1ns
`include "dac_consts.vh"

module dac_channel (
    input wire aclk,
    input wire aresetn,
    input wire wr_control,
    input wire wr_high,
    input wire wr_low,
    input wire [7:0] wdata,
    input wire [3:0] timer_event,
    input wire strobe_rise,
    input wire strobe_fall,
    output wire [7:0] control_read,
    output wire [7:0] high_read,
    output wire [7:0] low_read,
    output reg [11:0] latch_reg,
    output wire enable,
    output wire [1:0] fullscale
);

    // -----------------------------------------------------------------
    // held registers
    // -----------------------------------------------------------------
    reg [7:0] control_reg;
    reg [7:0] high_reg;
    reg [7:0] low_reg;
    wire [2:0] source;
    wire rjst;
    wire [7:0] high_eff;
    wire [11:0] word;
    reg update;

    assign source = control_reg[`CTL_SOURCE_MSB:`CTL_SOURCE_LSB];
    assign rjst = control_reg[`CTL_RJST_BIT];
    assign enable = control_reg[`CTL_ENABLE_BIT];
    assign fullscale = control_reg[`CTL_FS_MSB:`CTL_FS_LSB];
    assign control_read = {control_reg[7:4], 1'b0, control_reg[2:0]};
    assign high_read = rjst ? {4'h0, high_reg[3:0]} : high_reg;
    assign low_read = rjst ? low_reg : {low_reg[7:4], 4'h0};

    // high byte written this cycle takes part in its own update
    assign high_eff = wr_high ? wdata : high_reg;
    assign word = rjst ? {high_eff[3:0], low_reg}
                       : {high_eff, low_reg[7:4]};

    always @(posedge aclk) begin
        if (!aresetn) begin
            control_reg <= `CTL_RESET;
            high_reg <= `DATA_RESET;
            low_reg <= `DATA_RESET;
        end else begin
            if (wr_control) begin
                control_reg <= {wdata[7:4], 1'b0, wdata[2:0]};
            end
            if (wr_high) begin
                high_reg <= wdata;
            end
            if (wr_low) begin
                low_reg <= wdata;
            end
        end
    end

    // -----------------------------------------------------------------
    // update event selection
    // -----------------------------------------------------------------
    always @* begin
        case (source)
            `SRC_TIMER0: update = timer_event[0];
            `SRC_TIMER1: update = timer_event[1];
            `SRC_TIMER2: update = timer_event[2];
            `SRC_TIMER3: update = timer_event[3];
            `SRC_STROBE_RISE: update = strobe_rise;
            `SRC_STROBE_FALL: update = strobe_fall;
            `SRC_STROBE_ANY: update = strobe_rise | strobe_fall;
            `SRC_HIGH_WRITE: update = wr_high;
            default: update = 1'b0;
        endcase
    end

    // data bytes are held; only the selected event moves them on
    always @(posedge aclk) begin
        if (!aresetn) begin
            latch_reg <= 12'h000;
        end else if (update) begin
            latch_reg <= word;
        end
    end

endmodule

// >>> dual_dac_ctrl.v
// top of the dual current dac update control with its axi4-lite register slave
// Summary of operation
// - source codes 100/101/110 update on rising, falling or either strobe edge
// - strobe modes hold byte writes; the edge copies high:low into the latch
// - source codes 000 to 011 update on timer 0 to 3 overflow
// - source code 111 updates on a write to the high data byte
// - left justified: d11-d4 from high 7-0, d3-d0 from low 7-4
// - right justified: d11-d8 from high 3-0, d7-d0 from low 7-0
// - control bit 2 selects justification: 0 left, 1 right
// - control bits 1:0 pick 0.25, 0.5, 1 or 2 ma; reset 2 ma
// - control bit 7 enables the channel; resets to 0
// - control bit 3 reserved: reads 0, software writes 0
// - reference control bit 7 picks the second channel pin; first pin fixed
// - both disabled: pins are gpio; enabled pin loses driver and pullup
// - both enabled with merge set: both currents share the first pin
// - merge 0: second channel on own pin; 1: on first channel pin
// - write mode: low byte held until the high byte write latches both
// - timer 2/3 update on low overflow in 8-bit, high overflow in 16-bit
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "dac_consts.vh"

module dual_dac_ctrl #(
    parameter ADDR_WIDTH = 12
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire timer0_overflow,
    input wire timer1_overflow,
    input wire timer2_low_overflow,
    input wire timer2_high_overflow,
    input wire timer2_split_8bit,
    input wire timer3_low_overflow,
    input wire timer3_high_overflow,
    input wire timer3_split_8bit,
    input wire external_convert_strobe,
    output wire [11:0] dac0_code,
    output wire [11:0] dac1_code,
    output wire [1:0] dac0_fullscale_select,
    output wire [1:0] dac1_fullscale_select,
    output wire dac0_channel_enable,
    output wire dac1_channel_enable,
    output reg pin0_analog_connect,
    output reg pin1_analog_connect,
    output reg dac1_route_to_pin0
);

    // -----------------------------------------------------------------
    // write channel capture
    // -----------------------------------------------------------------
    // aw and w taken in either order, held until both in
    reg aw_held_reg;
    reg [ADDR_WIDTH-1:0] aw_addr_reg;
    reg w_held_reg;
    reg [7:0] w_data_reg;
    reg w_lane0_reg;
    wire aw_take;
    wire w_take;
    wire wr_fire;
    wire [7:0] wr_index;
    wire wr_hit;

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign wr_fire = aw_held_reg && w_held_reg;
    assign wr_index = aw_addr_reg[9:2];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= {ADDR_WIDTH{1'b0}};
        end else if (aw_take) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_lane0_reg <= 1'b0;
        end else if (w_take) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[7:0];
            w_lane0_reg <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // write address decode
    // -----------------------------------------------------------------
    // upper bytes of the word are read-only zero; only lane 0 stores
    reg wr_dac0_ctl;
    reg wr_dac0_high;
    reg wr_dac0_low;
    reg wr_dac1_ctl;
    reg wr_dac1_high;
    reg wr_dac1_low;
    reg wr_ref;
    reg wr_known;
    wire wr_go;

    assign wr_go = wr_fire && w_lane0_reg && aw_addr_reg[ADDR_WIDTH-1:10] == {(ADDR_WIDTH-10){1'b0}};

    always @* begin
        wr_dac0_ctl = 1'b0;
        wr_dac0_high = 1'b0;
        wr_dac0_low = 1'b0;
        wr_dac1_ctl = 1'b0;
        wr_dac1_high = 1'b0;
        wr_dac1_low = 1'b0;
        wr_ref = 1'b0;
        wr_known = 1'b1;
        case (wr_index)
            `IDX_DAC0_CONTROL: wr_dac0_ctl = wr_go;
            `IDX_DAC0_DATA_HIGH: wr_dac0_high = wr_go;
            `IDX_DAC0_DATA_LOW: wr_dac0_low = wr_go;
            `IDX_DAC1_CONTROL: wr_dac1_ctl = wr_go;
            `IDX_DAC1_DATA_HIGH: wr_dac1_high = wr_go;
            `IDX_DAC1_DATA_LOW: wr_dac1_low = wr_go;
            `IDX_REFERENCE_CONTROL: wr_ref = wr_go;
            default: wr_known = 1'b0;
        endcase
    end

    assign wr_hit = wr_known && (aw_addr_reg[ADDR_WIDTH-1:10] == {(ADDR_WIDTH-10){1'b0}});

    // -----------------------------------------------------------------
    // write response
    // -----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // reference control (merge bit only lives here)
    // -----------------------------------------------------------------
    // other reference bits live elsewhere, read zero
    localparam [7:0] REF_INIT = `REF_RESET;
    reg merge_reg;

    always @(posedge aclk) begin
        if (!aresetn) begin
            merge_reg <= REF_INIT[`REF_MERGE_BIT];
        end else if (wr_ref && wr_hit) begin
            merge_reg <= w_data_reg[`REF_MERGE_BIT];
        end
    end

    // -----------------------------------------------------------------
    // strobe synchroniser and edge detect
    // -----------------------------------------------------------------
    reg strobe_meta_reg;
    reg strobe_sync_reg;
    reg strobe_prev_reg;
    wire strobe_rise;
    wire strobe_fall;

    always @(posedge aclk) begin
        if (!aresetn) begin
            strobe_meta_reg <= 1'b0;
            strobe_sync_reg <= 1'b0;
            strobe_prev_reg <= 1'b0;
        end else begin
            strobe_meta_reg <= external_convert_strobe;
            strobe_sync_reg <= strobe_meta_reg;
            strobe_prev_reg <= strobe_sync_reg;
        end
    end

    // both samples synchronised: one pulse per edge
    assign strobe_rise = strobe_sync_reg && !strobe_prev_reg;
    assign strobe_fall = !strobe_sync_reg && strobe_prev_reg;

    // -----------------------------------------------------------------
    // timer event selection
    // -----------------------------------------------------------------
    wire [3:0] timer_event;

    assign timer_event[0] = timer0_overflow;
    assign timer_event[1] = timer1_overflow;
    assign timer_event[2] = timer2_split_8bit ? timer2_low_overflow : timer2_high_overflow;
    assign timer_event[3] = timer3_split_8bit ? timer3_low_overflow : timer3_high_overflow;

    // -----------------------------------------------------------------
    // channels
    // -----------------------------------------------------------------
    wire [7:0] ch0_ctl_rd;
    wire [7:0] ch0_high_rd;
    wire [7:0] ch0_low_rd;
    wire [7:0] ch1_ctl_rd;
    wire [7:0] ch1_high_rd;
    wire [7:0] ch1_low_rd;

    dac_channel u_dac0 (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_control(wr_dac0_ctl),
        .wr_high(wr_dac0_high),
        .wr_low(wr_dac0_low),
        .wdata(w_data_reg),
        .timer_event(timer_event),
        .strobe_rise(strobe_rise),
        .strobe_fall(strobe_fall),
        .control_read(ch0_ctl_rd),
        .high_read(ch0_high_rd),
        .low_read(ch0_low_rd),
        .latch_reg(dac0_code),
        .enable(dac0_channel_enable),
        .fullscale(dac0_fullscale_select)
    );

    dac_channel u_dac1 (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_control(wr_dac1_ctl),
        .wr_high(wr_dac1_high),
        .wr_low(wr_dac1_low),
        .wdata(w_data_reg),
        .timer_event(timer_event),
        .strobe_rise(strobe_rise),
        .strobe_fall(strobe_fall),
        .control_read(ch1_ctl_rd),
        .high_read(ch1_high_rd),
        .low_read(ch1_low_rd),
        .latch_reg(dac1_code),
        .enable(dac1_channel_enable),
        .fullscale(dac1_fullscale_select)
    );

    // -----------------------------------------------------------------
    // pin ownership
    // -----------------------------------------------------------------
    // crossbar skip bits stay with software; this only steers the pad
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin0_analog_connect <= 1'b0;
            pin1_analog_connect <= 1'b0;
            dac1_route_to_pin0 <= 1'b0;
        end else begin
            pin0_analog_connect <= dac0_channel_enable
                || (dac1_channel_enable && merge_reg);
            pin1_analog_connect <= dac1_channel_enable && !merge_reg;
            dac1_route_to_pin0 <= merge_reg;
        end
    end

    // -----------------------------------------------------------------
    // read path
    // -----------------------------------------------------------------
    wire [7:0] rd_index;
    wire rd_upper_ok;
    wire ar_take;
    reg [7:0] rd_byte;
    reg rd_known;

    assign s_axi_arready = !s_axi_rvalid;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rd_index = s_axi_araddr[9:2];
    assign rd_upper_ok = s_axi_araddr[ADDR_WIDTH-1:10] == {(ADDR_WIDTH-10){1'b0}};

    always @* begin
        rd_byte = 8'h00;
        rd_known = 1'b1;
        case (rd_index)
            `IDX_DAC0_CONTROL: rd_byte = ch0_ctl_rd;
            `IDX_DAC0_DATA_HIGH: rd_byte = ch0_high_rd;
            `IDX_DAC0_DATA_LOW: rd_byte = ch0_low_rd;
            `IDX_DAC1_CONTROL: rd_byte = ch1_ctl_rd;
            `IDX_DAC1_DATA_HIGH: rd_byte = ch1_high_rd;
            `IDX_DAC1_DATA_LOW: rd_byte = ch1_low_rd;
            `IDX_REFERENCE_CONTROL: rd_byte = {merge_reg, 7'h00};
            default: rd_known = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            if (rd_known && rd_upper_ok) begin
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= `RESP_OKAY;
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// >>> dac_far_side_model.sv
// far-side model: six overflow sources of four timers and the external convert strobe pin
`timescale 1ns/1ns
module timer_strobe_model (
    input wire aclk,
    output reg [5:0] ovf = 6'h00,
    output reg split2 = 1'b0,
    output reg split3 = 1'b0,
    output reg strobe = 1'b0
);
    // ---------------------------------------------------------------
    // stimulus tasks
    // ---------------------------------------------------------------
    // ovf bits: t0, t1, t2 low, t2 high, t3 low, t3 high
    task pulse(input integer n);
        begin
            @(posedge aclk);
            ovf[n] <= 1'b1;
            @(posedge aclk);
            ovf <= 6'h00;
        end
    endtask
    // held past the synchroniser
    task drive_pin(input logic v);
        begin
            @(posedge aclk);
            strobe <= v;
            repeat (5) @(posedge aclk);
        end
    endtask
    // split level: 1 = 8-bit timer mode
    task set_split(input logic a, input logic b);
        begin
            @(posedge aclk);
            split2 <= a;
            split3 <= b;
        end
    endtask
endmodule

// >>> dac_ctrl_asserts.sv
// concurrent checks on the ports of the dual dac control
`timescale 1ns/1ns
module dac_ctrl_checker (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire timer0_overflow,
    input wire timer1_overflow,
    input wire timer2_low_overflow,
    input wire timer2_high_overflow,
    input wire timer3_low_overflow,
    input wire timer3_high_overflow,
    input wire external_convert_strobe,
    input wire [11:0] dac0_code,
    input wire [1:0] dac0_fullscale_select,
    input wire dac0_channel_enable,
    input wire dac1_channel_enable,
    input wire pin0_analog_connect,
    input wire pin1_analog_connect,
    input wire dac1_route_to_pin0
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ---------------------------------------------------------------
    // strobe age: synchroniser adds three edges
    // ---------------------------------------------------------------
    reg strobe_prev;
    reg [2:0] strobe_age;
    wire any_ovf = timer0_overflow | timer1_overflow | timer2_low_overflow | timer2_high_overflow |
        timer3_low_overflow | timer3_high_overflow;
    always @(posedge aclk) begin
        strobe_prev <= external_convert_strobe;
        if (!aresetn)
            strobe_age <= 3'h7;
        else if (external_convert_strobe != strobe_prev)
            strobe_age <= 3'h0;
        else if (strobe_age != 3'h7)
            strobe_age <= strobe_age + 3'h1;
    end
    AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late or early");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    AST_W_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    AST_R_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while pending");
    AST_CODE_CAUSE: assert property (dac0_code != $past(dac0_code) |->
        $rose(s_axi_bvalid) || $past(any_ovf) || strobe_age < 3'h5) else $error("code moved without event");
    AST_PIN0: assert property (pin0_analog_connect == ($past(dac0_channel_enable) ||
        ($past(dac1_channel_enable) && dac1_route_to_pin0))) else $error("first pin connect wrong");
    AST_PIN1: assert property (pin1_analog_connect == ($past(dac1_channel_enable) &&
        !dac1_route_to_pin0)) else $error("second pin connect wrong");
    AST_RESET_DEF: assert property ($rose(aresetn) |-> dac0_fullscale_select == 2'h3 &&
        !dac0_channel_enable && dac0_code == 12'h000) else $error("reset defaults wrong");
endmodule
bind dual_dac_ctrl dac_ctrl_checker chk (.*);

// >>> tb_dual_dac.sv
// self-checking bench for the dual current dac update control
`timescale 1ns/1ns
`include "dac_consts.vh"
module tb;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg [11:0] awaddr = 12'h000;
    reg [11:0] araddr = 12'h000;
    reg [31:0] wdata = 32'h00000000;
    reg [3:0] wstrb = 4'h1;
    reg awvalid = 1'b0;
    reg wvalid = 1'b0;
    reg bready = 1'b0;
    reg arvalid = 1'b0;
    reg rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, en0, en1, pin0, pin1, route, split2, split3, strobe;
    wire [1:0] bresp, rresp, fs0, fs1;
    wire [31:0] rdata;
    wire [11:0] code0, code1;
    wire [5:0] ovf;
    integer failures = 0;
    integer comparisons = 0;
    integer cycles = 0;
    // rows: source, split2, split3, ignored event, updating event
    localparam [199:0] ROWS = 200'h60026_60017_40006_50067_30045_30154_20023_21032_10001_00010;
    always #25 aclk = ~aclk;
    dual_dac_ctrl dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .timer0_overflow(ovf[0]), .timer1_overflow(ovf[1]), .timer2_low_overflow(ovf[2]),
        .timer2_high_overflow(ovf[3]), .timer2_split_8bit(split2), .timer3_low_overflow(ovf[4]),
        .timer3_high_overflow(ovf[5]), .timer3_split_8bit(split3), .external_convert_strobe(strobe),
        .dac0_code(code0), .dac1_code(code1), .dac0_fullscale_select(fs0), .dac1_fullscale_select(fs1),
        .dac0_channel_enable(en0), .dac1_channel_enable(en1), .pin0_analog_connect(pin0),
        .pin1_analog_connect(pin1), .dac1_route_to_pin0(route)
    );
    timer_strobe_model m (.aclk(aclk), .ovf(ovf), .split2(split2), .split3(split3), .strobe(strobe));
    // ---------------------------------------------------------------
    // compare, bus and event tasks
    // ---------------------------------------------------------------
    task give_verdict;
        begin
            $display("comparisons %0d failures %0d", comparisons, failures);
            if (failures == 0 && comparisons > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task check(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task check_resp(input [1:0] got, input [1:0] exp);
        check({30'h0, got}, {30'h0, exp});
    endtask
    // sample at negedge, act after the next posedge
    task wr(input [7:0] idx, input [7:0] d, input [1:0] er);
        reg a, w, b;
        begin
            @(posedge aclk);
            awaddr <= {2'h0, idx, 2'h0};
            wdata <= {24'h0, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            b = 1'b0;
            while (!b) begin
                @(negedge aclk);
                a = awvalid && awready;
                w = wvalid && wready;
                b = bvalid;
                if (b)
                    check_resp(bresp, er);
                @(posedge aclk);
                if (a)
                    awvalid <= 1'b0;
                if (w)
                    wvalid <= 1'b0;
                if (b)
                    bready <= 1'b0;
            end
        end
    endtask
    task rd(input [7:0] idx, input [7:0] exp, input [1:0] er);
        reg a, r;
        begin
            @(posedge aclk);
            araddr <= {2'h0, idx, 2'h0};
            arvalid <= 1'b1;
            rready <= 1'b1;
            r = 1'b0;
            while (!r) begin
                @(negedge aclk);
                a = arvalid && arready;
                r = rvalid;
                if (r) begin
                    check(rdata, {24'h0, exp});
                    check_resp(rresp, er);
                end
                @(posedge aclk);
                if (a)
                    arvalid <= 1'b0;
                if (r)
                    rready <= 1'b0;
            end
        end
    endtask
    task fire(input [3:0] e);
        begin
            if (e < 4'h6)
                m.pulse(e);
            else
                m.drive_pin(e == 4'h6);
            @(negedge aclk);
        end
    endtask
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            give_verdict;
        end
    end
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        integer i, k, ch;
        reg [19:0] r;
        reg [7:0] h, l;
        reg [11:0] prev;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`IDX_DAC0_CONTROL, `CTL_RESET, `RESP_OKAY);
        rd(`IDX_DAC1_CONTROL, `CTL_RESET, `RESP_OKAY);
        rd(`IDX_DAC1_DATA_HIGH, `DATA_RESET, `RESP_OKAY);
        rd(`IDX_REFERENCE_CONTROL, `REF_RESET, `RESP_OKAY);
        check(fs1, 2'h3);
        check(code1, 12'h000);
        rd(8'h00, 8'h00, `RESP_SLVERR);
        wr(8'h00, 8'h55, `RESP_SLVERR);
        for (i = 0; i < 4; i = i + 1) begin
            wr(`IDX_DAC0_CONTROL, 8'h70 | i[7:0], `RESP_OKAY);
            check(fs0, i[1:0]);
        end
        // write mode: low waits for high
        wr(`IDX_DAC0_DATA_LOW, 8'ha5, `RESP_OKAY);
        check(code0, 12'h000);
        rd(`IDX_DAC0_DATA_LOW, 8'ha0, `RESP_OKAY);
        wr(`IDX_DAC0_DATA_HIGH, 8'h3c, `RESP_OKAY);
        check(code0, 12'h3ca);
        wr(`IDX_DAC0_CONTROL, 8'h7c, `RESP_OKAY);
        rd(`IDX_DAC0_CONTROL, 8'h74, `RESP_OKAY);
        wr(`IDX_DAC0_DATA_HIGH, 8'hf6, `RESP_OKAY);
        check(code0, 12'h6a5);
        rd(`IDX_DAC0_DATA_HIGH, 8'h06, `RESP_OKAY);
        // timer and strobe sources on both channels
        for (ch = 0; ch < 2; ch = ch + 1) begin
            for (k = 0; k < 10; k = k + 1) begin
                r = ROWS[k*20 +: 20];
                m.set_split(r[15:12] != 4'h0, r[11:8] != 4'h0);
                wr(ch ? `IDX_DAC1_CONTROL : `IDX_DAC0_CONTROL, {1'b0, r[18:16], 4'h3}, `RESP_OKAY);
                h = 8'h13 * (k + 1) + ch;
                l = ~h;
                prev = ch ? code1 : code0;
                wr(ch ? `IDX_DAC1_DATA_HIGH : `IDX_DAC0_DATA_HIGH, h, `RESP_OKAY);
                wr(ch ? `IDX_DAC1_DATA_LOW : `IDX_DAC0_DATA_LOW, l, `RESP_OKAY);
                check(ch ? code1 : code0, prev);
                fire(r[7:4]);
                check(ch ? code1 : code0, prev);
                fire(r[3:0]);
                check(ch ? code1 : code0, {h, l[7:4]});
            end
        end
        // pin ownership for every enable and merge combination; skip bits stay with software
        for (i = 0; i < 8; i = i + 1) begin
            wr(`IDX_DAC0_CONTROL, {i[0], 7'h73}, `RESP_OKAY);
            wr(`IDX_DAC1_CONTROL, {i[1], 7'h73}, `RESP_OKAY);
            wr(`IDX_REFERENCE_CONTROL, {i[2], 7'h00}, `RESP_OKAY);
            repeat (2) @(negedge aclk);
            check(en0, i[0]);
            check(en1, i[1]);
            check(pin0, i[0] | (i[1] & i[2]));
            check(pin1, i[1] & ~i[2]);
            check(route, i[2]);
        end
        give_verdict;
    end
endmodule
